// file: lamp_pkg.sv
package lamp_pkg;
   // ***********************************************
   // widths and counts
   // ***********************************************
   localparam int PORT_COUNT        = 10;
   localparam int LAMP_WORD_WIDTH   = 8;
   localparam int STRAP_WIDTH       = 16;
   localparam int SERIAL_BITS       = 16;
   localparam int SER_DIV_CYCLES    = 4;
   localparam int SER_GAP_CYCLES    = 8;
   localparam int PARALLEL_DWELL    = 4;
   localparam int PORT_SEL_LOW      = 8;
   // ***********************************************
   // reset values of captured straps
   // ***********************************************
   localparam logic [15:0] STRAP_RESET    = 16'hFFFF;
   localparam logic        BLINK_RESET    = 1'b1;
   localparam logic        PARALLEL_RESET = 1'b1;
   localparam logic [1:0]  TEST_RESET     = 2'h3;

   // one lamp pin group: output, enable
   typedef struct packed {
      logic [15:0] data;
      logic [15:0] oe;
   } shared_pins_type;

   typedef struct packed {
      logic blink_disable;
      logic parallel_mode;
      logic [1:0] test_select;
      logic [15:0] straps;
   } strap_set_type;

   typedef enum logic [2:0] {
      SER_IDLE  = 3'b001,
      SER_SHIFT = 3'b010,
      SER_GAP   = 3'b100
   } ser_state_type;
endpackage

// file: lamp_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser, vector wide
module lamp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // first stage is only read by the second; no reset, so that strap
   // levels keep flowing through while the device is held in reset
   always_ff @(posedge clk_i) begin
      meta   <= async_i;
      sync_o <= meta;
   end
endmodule

// file: lamp_pin_control.sv
`timescale 1ns/100ps
//
// Contract
// - capture sixteen straps in reset, drive afterwards
// - blink strap high means no blinking
// - mode strap high parallel, low serial
// - serial clock on port select bit eight
// - serial data on port select bit nine
// - active low envelope frames serial stream
// - parallel lamp word on low byte
// - ten bit port select across pins
// - latch test pins, drive nand results
module lamp_pin_control
   import lamp_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          arst_n_i,
   input  wire logic [lamp_pkg::STRAP_WIDTH-1:0] shared_pin_i,
   output logic      [lamp_pkg::STRAP_WIDTH-1:0] shared_pin_o,
   output logic      [lamp_pkg::STRAP_WIDTH-1:0] shared_pin_oe_o,
   input  wire logic                          port_sel8_pin_i,
   output logic                               port_sel8_pin_o,
   output logic                               port_sel8_pin_oe_o,
   input  wire logic                          blink_pin_i,
   output logic                               blink_pin_o,
   output logic                               blink_pin_oe_o,
   input  wire logic                          envelope_pin_i,
   output logic                               envelope_pin_o,
   output logic                               envelope_pin_oe_o,
   input  wire logic                          test_select_pin_a_i,
   input  wire logic                          test_select_pin_b_i,
   output logic                               test_select_pin_a_o,
   output logic                               test_select_pin_b_o,
   output logic                               test_select_pin_oe_o,
   input  wire logic                          scan_enable_i,
   input  wire logic [1:0]                    nand_tree_result_i,
   input  wire logic [lamp_pkg::PORT_COUNT-1:0]  lamp_status_i,
   input  wire logic                          blink_phase_i,
   output lamp_pkg::strap_set_type            strap_set_o,
   output logic                               test_mode_o
);
   import lamp_pkg::*;

   // ***********************************************
   // reset tracking and pin synchronisers
   // ***********************************************
   logic                    in_reset;
   logic [STRAP_WIDTH+4:0]  pins_raw;
   logic [STRAP_WIDTH+4:0]  pins_sync;
   logic                    scan_sync;

   // every strap pin and scan enable share one synchroniser
   assign pins_raw = {scan_enable_i, test_select_pin_b_i, test_select_pin_a_i,
                      envelope_pin_i, blink_pin_i, shared_pin_i};

   // synchroniser runs through reset: a reset one would hide the straps
   // until after the capture edge and every strap would read as ones
   lamp_sync #(.WIDTH(STRAP_WIDTH+5)) u_sync (
      .clk_i    (clk_i),
      .async_i  (pins_raw),
      .sync_o   (pins_sync)
   );
   assign scan_sync = pins_sync[STRAP_WIDTH+4];

   // first clocked cycle after release still samples, then drives
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_reset <= 1'b1;
      end else begin
         in_reset <= 1'b0;
      end
   end

   // ***********************************************
   // strap capture
   // ***********************************************
   // straps are caught by a clock at release, never by the async reset itself
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strap_set_o.straps        <= STRAP_RESET;
         strap_set_o.blink_disable <= BLINK_RESET;
         strap_set_o.parallel_mode <= PARALLEL_RESET;
         strap_set_o.test_select   <= TEST_RESET;
      end else if (in_reset) begin
         strap_set_o.straps        <= pins_sync[STRAP_WIDTH-1:0];
         strap_set_o.blink_disable <= pins_sync[STRAP_WIDTH];
         strap_set_o.parallel_mode <= pins_sync[STRAP_WIDTH+1];
         strap_set_o.test_select   <= pins_sync[STRAP_WIDTH+3:STRAP_WIDTH+2];
      end
   end

   // scan enable pulled low by default keeps normal mode
   assign test_mode_o = scan_sync & ~in_reset;

   // ***********************************************
   // lamp state with optional blinking
   // ***********************************************
   logic [PORT_COUNT-1:0] lamp_shown;

   // one phase gates every lamp, so all blinking ports flash in step
   always_comb begin
      if (strap_set_o.blink_disable) begin
         lamp_shown = lamp_status_i;
      end else begin
         lamp_shown = lamp_status_i & {PORT_COUNT{blink_phase_i}};
      end
   end

   // ***********************************************
   // parallel scan: one port at a time
   // ***********************************************
   logic [3:0]            par_port;
   logic [2:0]            par_dwell;
   logic [PORT_COUNT-1:0] par_sel;
   logic [LAMP_WORD_WIDTH-1:0] par_word;

   // select and word register together so the pins never pair mismatched
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         par_port  <= 4'h0;
         par_dwell <= 3'h0;
         par_sel   <= '0;
         par_word  <= '0;
      end else begin
         if (par_dwell == 3'(PARALLEL_DWELL - 1)) begin
            par_dwell <= 3'h0;
            par_port  <= (par_port == 4'(PORT_COUNT - 1)) ? 4'h0 : par_port + 4'h1;
         end else begin
            par_dwell <= par_dwell + 3'h1;
         end
         par_sel  <= PORT_COUNT'(1) << par_port;
         par_word <= {{(LAMP_WORD_WIDTH-1){1'b0}}, lamp_shown[par_port]};
      end
   end

   // ***********************************************
   // serial shifter
   // ***********************************************
   ser_state_type          ser_state;
   logic [1:0]             ser_div;
   logic [4:0]             ser_count;
   logic [SERIAL_BITS-1:0] ser_shift;
   logic                   ser_clk;
   logic                   ser_env_n;

   // clock low for half the bit, high for half; data changes on falling edge
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ser_state <= SER_IDLE;
         ser_div   <= 2'h0;
         ser_count <= 5'h0;
         ser_shift <= '0;
         ser_clk   <= 1'b0;
         ser_env_n <= 1'b1;
      end else begin
         unique case (ser_state)
            SER_IDLE: begin
               ser_shift <= SERIAL_BITS'(lamp_shown);
               ser_env_n <= 1'b0;
               ser_count <= 5'h0;
               ser_div   <= 2'h0;
               ser_state <= SER_SHIFT;
            end
            SER_SHIFT: begin
               ser_div <= ser_div + 2'h1;
               ser_clk <= (ser_div >= 2'(SER_DIV_CYCLES / 2 - 1))
                          && (ser_div != 2'(SER_DIV_CYCLES - 1));
               if (ser_div == 2'(SER_DIV_CYCLES - 1)) begin
                  ser_shift <= ser_shift >> 1;
                  if (ser_count == 5'(SERIAL_BITS - 1)) begin
                     ser_env_n <= 1'b1;
                     ser_count <= 5'h0;
                     ser_state <= SER_GAP;
                  end else begin
                     ser_count <= ser_count + 5'h1;
                  end
               end
            end
            SER_GAP: begin
               ser_clk   <= 1'b0;
               ser_count <= ser_count + 5'h1;
               if (ser_count == 5'(SER_GAP_CYCLES - 1)) begin
                  ser_state <= SER_IDLE;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // pin muxing
   // ***********************************************
   // pins stay inputs one cycle past release so the capture sees straps
   logic drive;
   assign drive = ~in_reset;

   // mode strap picks which engine owns the shared pins
   always_comb begin
      shared_pin_oe_o    = {STRAP_WIDTH{drive}};
      blink_pin_oe_o     = drive;
      envelope_pin_oe_o  = drive;
      port_sel8_pin_oe_o = drive;
      if (strap_set_o.parallel_mode) begin
         shared_pin_o    = {par_sel[PORT_SEL_LOW-1:0], par_word};
         port_sel8_pin_o = par_sel[8];
         blink_pin_o     = par_sel[9];
         envelope_pin_o  = 1'b1;
      end else begin
         shared_pin_o    = '0;
         port_sel8_pin_o = ser_clk;
         blink_pin_o     = ser_shift[0];
         envelope_pin_o  = ser_env_n;
      end
   end

   // test pins drive nand results only in test mode
   assign test_select_pin_oe_o = test_mode_o;
   assign test_select_pin_a_o  = nand_tree_result_i[0];
   assign test_select_pin_b_o  = nand_tree_result_i[1];
endmodule

// file: lamp_pin_checker.sv
`timescale 1ns/100ps
// ****
// pin timing checker
// ****
module lamp_pin_checker
   import lamp_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          arst_n_i,
   input  wire logic [15:0]   shared_pin_o,
   input  wire logic [15:0]   shared_pin_oe_o,
   input  wire logic          port_sel8_pin_o,
   input  wire logic          envelope_pin_o,
   input  wire logic          envelope_pin_oe_o,
   input  wire logic          test_select_pin_a_o,
   input  wire logic          test_select_pin_b_o,
   input  wire logic          test_select_pin_oe_o,
   input  wire logic          scan_enable_i,
   input  wire logic [1:0]    nand_tree_result_i,
   input  lamp_pkg::strap_set_type strap_set_o,
   input  wire logic          test_mode_o
);
   import lamp_pkg::*;
   logic [7:0] low_count;
   logic [4:0] clk_rises;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // envelope length and lamp clocks counted per frame
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_count <= 8'h00;
         clk_rises <= 5'h00;
      end else if (envelope_pin_o || !envelope_pin_oe_o) begin
         low_count <= 8'h00;
         clk_rises <= 5'h00;
      end else begin
         low_count <= low_count + 8'h01;
         clk_rises <= clk_rises + {4'h0, $rose(port_sel8_pin_o)};
      end
   end
   sequence s_release; $rose(arst_n_i); endsequence
   sequence s_frame_end;
      $rose(envelope_pin_o) && !strap_set_o.parallel_mode && $past(envelope_pin_oe_o);
   endsequence
   property p_release; s_release |-> shared_pin_oe_o == 16'h0000 ##2 shared_pin_oe_o == 16'hFFFF;
   endproperty
   a_release: assert property (p_release) else $error("pin enables wrong after reset");
   property p_test_out;
      test_mode_o |-> test_select_pin_oe_o && {test_select_pin_b_o, test_select_pin_a_o} == nand_tree_result_i;
   endproperty
   a_test_out: assert property (p_test_out) else $error("test pins not driven");
   property p_test_off; !test_mode_o |-> !test_select_pin_oe_o; endproperty
   a_test_off: assert property (p_test_off) else $error("test pins driven outside test");
   property p_scan; $rose(scan_enable_i) |-> ##[1:4] test_mode_o; endproperty
   a_scan: assert property (p_scan) else $error("scan enable ignored");
   property p_par_env; strap_set_o.parallel_mode && envelope_pin_oe_o |-> envelope_pin_o;
   endproperty
   a_par_env: assert property (p_par_env) else $error("envelope low in parallel");
   property p_ser_quiet;
      !strap_set_o.parallel_mode && shared_pin_oe_o[0] |-> shared_pin_o == 16'h0000;
   endproperty
   a_ser_quiet: assert property (p_ser_quiet) else $error("word pins busy in serial");
   property p_env_len; s_frame_end |-> low_count == 8'h40; endproperty
   a_env_len: assert property (p_env_len) else $error("envelope length wrong");
   property p_clk_count; s_frame_end |-> clk_rises == 5'h10; endproperty
   a_clk_count: assert property (p_clk_count) else $error("lamp clock count wrong");
endmodule
bind lamp_pin_control lamp_pin_checker i_lamp_pin_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .shared_pin_o(shared_pin_o), .shared_pin_oe_o(shared_pin_oe_o),
   .port_sel8_pin_o(port_sel8_pin_o), .envelope_pin_o(envelope_pin_o),
   .envelope_pin_oe_o(envelope_pin_oe_o), .test_select_pin_a_o(test_select_pin_a_o),
   .test_select_pin_b_o(test_select_pin_b_o), .test_select_pin_oe_o(test_select_pin_oe_o),
   .scan_enable_i(scan_enable_i), .nand_tree_result_i(nand_tree_result_i),
   .strap_set_o(strap_set_o), .test_mode_o(test_mode_o));

// file: lamp_far_side.sv
`timescale 1ns/100ps
// ****
// strap resistors and lamp shift register
// ****
module lamp_far_side (
   input  wire logic [18:0] strap_i,
   input  wire logic [18:0] dev_o_i,
   input  wire logic [18:0] dev_oe_i,
   output logic      [18:0] wire_o,
   output logic      [15:0] frame_o,
   output int               frames_o
);
   logic [15:0] shift = 16'h0000;
   int          idx = 0;
   initial frames_o = 0;
   // undriven pins fall to the strap resistor level
   assign wire_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & strap_i);
   // one bit per lamp clock inside the envelope
   always @(posedge wire_o[16]) begin
      if (!wire_o[18] && idx < 16) begin
         shift[idx] = wire_o[17];
         idx = idx + 1;
      end
   end
   // envelope end closes the frame
   always @(posedge wire_o[18]) begin
      frame_o = shift;
      frames_o = frames_o + 1;
      idx = 0;
   end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   import lamp_pkg::*;
   logic          clk_i = 1'b0;
   logic          arst_n_i = 1'b0;
   logic          scan_enable_i = 1'b0;
   logic [1:0]    nand_tree_result_i = 2'h2;
   logic [9:0]    lamp_status_i = 10'h2B5;
   logic [18:0]   strap = 19'h7FFFF;
   logic [1:0]    test_strap = 2'h3;
   logic          blink_phase = 1'b0;
   logic [9:0]    psel;
   logic [7:0]    pexp;
   logic [18:0]   dev_o, dev_oe, pin;
   logic [15:0]   shared_o, shared_oe, frame;
   logic          sel8_o, sel8_oe, blink_o, blink_oe, env_o, env_oe, ta_o, tb_o, t_oe;
   logic          test_mode_o;
   strap_set_type strap_set_o;
   int            frames, n, miscompares = 0, samples_checked = 0;
   // rows: blink strap, mode strap, test pins b/a, sixteen straps
   logic [19:0]   rows [4] = '{20'hFA5C3, 20'h15A3C, 20'hA0F0F, 20'h43C3C};
   assign dev_o = {env_o, blink_o, sel8_o, shared_o};
   assign dev_oe = {env_oe, blink_oe, sel8_oe, shared_oe};
   lamp_pin_control i_lamp_pin_control (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .shared_pin_i(pin[15:0]), .shared_pin_o(shared_o), .shared_pin_oe_o(shared_oe),
      .port_sel8_pin_i(pin[16]), .port_sel8_pin_o(sel8_o), .port_sel8_pin_oe_o(sel8_oe),
      .blink_pin_i(pin[17]), .blink_pin_o(blink_o), .blink_pin_oe_o(blink_oe),
      .envelope_pin_i(pin[18]), .envelope_pin_o(env_o), .envelope_pin_oe_o(env_oe),
      .test_select_pin_a_i(t_oe ? ta_o : test_strap[0]),
      .test_select_pin_b_i(t_oe ? tb_o : test_strap[1]),
      .test_select_pin_a_o(ta_o), .test_select_pin_b_o(tb_o), .test_select_pin_oe_o(t_oe),
      .scan_enable_i(scan_enable_i), .nand_tree_result_i(nand_tree_result_i),
      .lamp_status_i(lamp_status_i), .blink_phase_i(blink_phase), .strap_set_o(strap_set_o),
      .test_mode_o(test_mode_o));
   lamp_far_side i_lamp_far_side (.strap_i(strap), .dev_o_i(dev_o), .dev_oe_i(dev_oe),
      .wire_o(pin), .frame_o(frame), .frames_o(frames));
   // free running clock
   initial forever #12.5 clk_i = ~clk_i;
   task automatic summarize;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // straps held across the whole reset, released three cycles later
   task automatic do_reset(input logic [19:0] r);
      strap <= {r[18], r[19], 1'b0, r[15:0]};
      test_strap <= r[17:16];
      arst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask
   // hang guard, well beyond four resets and frames
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      summarize();
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset(rows[i]);
         `CHECK(strap_set_o, rows[i])
         `CHECK(shared_oe, 16'hFFFF)
         `CHECK({t_oe, test_mode_o}, 2'h0)
         if (!rows[i][18]) begin
            n = frames;
            for (int k = 0; k < 300 && frames < n + 2; k++) @(posedge clk_i);
            `CHECK(frames >= n + 2, 1'b1)
            `CHECK(frame, {6'h00, lamp_status_i & {10{rows[i][19]}}})
            lamp_status_i <= ~lamp_status_i;
         end else begin
            // walk every port once, four samples each; blink phase held dark
            for (int k = 0; k < 40; k++) begin
               @(negedge clk_i);
               psel = pin[17:8];
               pexp = 8'h00;
               for (int p = 0; p < PORT_COUNT; p++) begin
                  if (psel[p]) begin
                     pexp = {7'h00, lamp_status_i[p] & rows[i][19]};
                  end
               end
               `CHECK($onehot(psel), 1'b1)
               `CHECK(pin[7:0], pexp)
            end
            @(posedge clk_i);
         end
         $display("strap row %0d done", i);
      end
      scan_enable_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      `CHECK(test_mode_o, 1'b1)
      `CHECK({tb_o, ta_o}, nand_tree_result_i)
      $display("test mode done");
      summarize();
   end
endmodule
